// ===== hw/gpc_consts.svh
`ifndef GPC_CONSTS_SVH
`define GPC_CONSTS_SVH

`define GPC_NPINS      20
`define GPC_BUS_PIN_A  4
`define GPC_BUS_PIN_B  5
`define GPC_CMP_PIN_A  17
`define GPC_CMP_PIN_B  18
`define GPC_ADC_PIN0   0
`define GPC_ADC_NSH    4
`define GPC_ADC_CH0    3'h2
`define GPC_PULL_RST   1'b1
`define GPC_DIR_RST    1'b0
`define GPC_OUT_RST    1'b0
`define GPC_OEN_OFF    1'b1
`define GPC_CLK_NS     40
`define GPC_FILT_NS    160
`define GPC_FILT_CYC   ((`GPC_FILT_NS / `GPC_CLK_NS) < 1 ? 1 : \
                        (`GPC_FILT_NS / `GPC_CLK_NS))

`endif

// ===== hw/gpc_pkg.sv
package gpc_pkg;

   typedef enum logic [2:0]
   {
      GPC_RUN   = 3'b001,
      GPC_SLEEP = 3'b010,
      GPC_DEEP  = 3'b100
   } gpc_pwr_e;

endpackage : gpc_pkg

// ===== hw/gpc_insync.sv
`timescale 1ns/1ps
`include "gpc_consts.svh"

// three-stage input synchroniser; a level is taken once stages two and
// three agree, and where the filter is on it must also hold for FILT cycles
module gpc_insync #(
   parameter int W    = 1,
   parameter int FILT = `GPC_FILT_CYC
) (
   input  wire logic         i_clk,
   input  wire logic         i_rstn,
   input  wire logic [W-1:0] i_async,
   input  wire logic [W-1:0] i_filt_en,
   output logic      [W-1:0] o_lvl
);
   localparam int CW = $clog2(FILT + 1);

   typedef struct packed {
      logic [W-1:0]         s1;
      logic [W-1:0]         s2;
      logic [W-1:0]         s3;
      logic [W-1:0]         lvl;
      logic [W-1:0][CW-1:0] cnt;
   } gpc_sync_s;

   gpc_sync_s st_q;
   gpc_sync_s st_d;

   always_comb
   begin
      st_d    = st_q;
      st_d.s1 = i_async;
      st_d.s2 = st_q.s1;
      st_d.s3 = st_q.s2;
      for (int i = 0; i < W; i++)
      begin
         if ((st_q.s2[i] != st_q.s3[i]) || (st_q.s3[i] == st_q.lvl[i]))
            st_d.cnt[i] = '0;
         else if (!i_filt_en[i])
            st_d.lvl[i] = st_q.s3[i];
         else if (st_q.cnt[i] >= CW'(FILT - 1))
         begin
            st_d.lvl[i] = st_q.s3[i];
            st_d.cnt[i] = '0;
         end
         else
            st_d.cnt[i] = st_q.cnt[i] + CW'(1);
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_rstn)
         st_q <= '0;
      else
         st_q <= st_d;
   end

   assign o_lvl = st_q.lvl;

endmodule : gpc_insync

// ===== hw/gpc_top.sv
`timescale 1ns/1ps
`include "gpc_consts.svh"
// Operation
// - own-function pins are bidirectional, weak pull software can disable.
// - an enabled peripheral sets direction over the pin's own setting.
// - pull enable ignores function and direction; enabled after reset.
// - two bus pins have pin mode and open-drain bus mode with filter.
// - in reset peripherals are off and all pins are undriven inputs.
// - in sleep and deep sleep pins keep direction and level from entry.
// - an input pin with interrupt enabled wakes the chip on an event.
// - converter and comparator are off in reset, sleep and deep sleep, except the comparator stays on in sleep when its wake is enabled.
// - in sleep the comparator output may wake the chip when enabled.
// - converter reference is internal or external pin, chosen by software.
// - channels 2-5 share pins 0-3; comparator inputs share pins 17, 18.
module gpc_top #(
   parameter int N_PINS = `GPC_NPINS
) (
   input  wire logic              I_CORE_CLK,
   input  wire logic              I_RSTN,
   input  wire logic              I_CFG_WE,
   input  wire logic [N_PINS-1:0] I_CFG_DIR,
   input  wire logic [N_PINS-1:0] I_CFG_OUT,
   input  wire logic [N_PINS-1:0] I_CFG_PULL,
   input  wire logic [N_PINS-1:0] I_CFG_IRQ,
   input  wire logic              I_CFG_BUS_MODE,
   input  wire logic              I_CFG_VREF_EXT,
   input  wire logic              I_CFG_CMP_WAKE,
   input  wire logic [N_PINS-1:0] I_ALT_EN,
   input  wire logic [N_PINS-1:0] I_ALT_OE,
   input  wire logic [N_PINS-1:0] I_ALT_OUT,
   input  wire logic              I_ADC_EN,
   input  wire logic [2:0]        I_ADC_CH,
   input  wire logic              I_CMP_EN,
   input  wire logic              I_CMP_OUT,
   input  wire logic              I_SLEEP,
   input  wire logic              I_DEEP_SLEEP,
   input  wire logic [N_PINS-1:0] I_PAD_IN,
   output logic      [N_PINS-1:0] O_PAD_OUT,
   output logic      [N_PINS-1:0] O_PAD_OE_N,
   output logic      [N_PINS-1:0] O_PULL_EN,
   output logic      [N_PINS-1:0] O_ANA_SW,
   output logic      [1:0]        O_BUS_FILT_EN,
   output logic      [N_PINS-1:0] O_RD_DIR,
   output logic      [N_PINS-1:0] O_RD_OUT,
   output logic      [N_PINS-1:0] O_RD_PULL,
   output logic      [N_PINS-1:0] O_RD_IN,
   output logic                   O_PERIPH_ON,
   output logic                   O_ADC_PWR,
   output logic                   O_CMP_PWR,
   output logic                   O_VREF_EXT,
   output logic                   O_WAKE,
   output gpc_pkg::gpc_pwr_e      O_PWR_STATE
);
   import gpc_pkg::*;

   typedef struct packed {
      gpc_pwr_e          pwr;
      logic [N_PINS-1:0] dir;
      logic [N_PINS-1:0] out;
      logic [N_PINS-1:0] pull;
      logic [N_PINS-1:0] irq;
      logic [N_PINS-1:0] hold_dir;
      logic [N_PINS-1:0] hold_out;
      logic [N_PINS-1:0] pad_out;
      logic [N_PINS-1:0] pad_oe_n;
      logic [N_PINS-1:0] ana_sw;
      logic [N_PINS-1:0] in_prev;
      logic [1:0]        filt;
      logic              bus_mode;
      logic              vref_ext;
      logic              cmp_wake;
      logic              cmp_prev;
      logic              adc_pwr;
      logic              cmp_pwr;
      logic              periph_on;
      logic              wake;
   } gpc_top_s;

   gpc_top_s          st_q;
   gpc_top_s          st_d;
   logic [N_PINS-1:0] in_lvl;
   logic [N_PINS-1:0] filt_en;
   logic [0:0]        cmp_lvl;

   function automatic logic is_bus_pin(input int i);
      return (i == `GPC_BUS_PIN_A) || (i == `GPC_BUS_PIN_B);
   endfunction : is_bus_pin

   function automatic logic is_cmp_pin(input int i);
      return (i == `GPC_CMP_PIN_A) || (i == `GPC_CMP_PIN_B);
   endfunction : is_cmp_pin

   always_comb
   begin
      filt_en = '0;
      for (int i = 0; i < N_PINS; i++)
         filt_en[i] = is_bus_pin(i) & st_q.bus_mode;
   end

   gpc_insync #(
      .W    (N_PINS),
      .FILT (`GPC_FILT_CYC)
   ) u_pin_sync (
      .i_clk     (I_CORE_CLK),
      .i_rstn    (I_RSTN),
      .i_async   (I_PAD_IN),
      .i_filt_en (filt_en),
      .o_lvl     (in_lvl)
   );

   gpc_insync #(
      .W    (1),
      .FILT (`GPC_FILT_CYC)
   ) u_cmp_sync (
      .i_clk     (I_CORE_CLK),
      .i_rstn    (I_RSTN),
      .i_async   (I_CMP_OUT),
      .i_filt_en (1'b0),
      .o_lvl     (cmp_lvl)
   );

   always_comb
   begin
      logic              run;
      logic              drv_dir;
      logic              drv_out;
      logic [N_PINS-1:0] eff_dir;
      logic [N_PINS-1:0] eff_out;
      logic [N_PINS-1:0] pin_evt;
      run     = 1'b0;
      drv_dir = 1'b0;
      drv_out = 1'b0;
      eff_dir = '0;
      eff_out = '0;
      pin_evt = '0;
      st_d    = st_q;

      if (I_CFG_WE)
      begin
         st_d.dir      = I_CFG_DIR;
         st_d.out      = I_CFG_OUT;
         st_d.pull     = I_CFG_PULL;
         st_d.irq      = I_CFG_IRQ;
         st_d.bus_mode = I_CFG_BUS_MODE;
         st_d.vref_ext = I_CFG_VREF_EXT;
         st_d.cmp_wake = I_CFG_CMP_WAKE;
      end

      // deep sleep wins when both requests are up
      if (I_DEEP_SLEEP)
         st_d.pwr = GPC_DEEP;
      else if (I_SLEEP)
         st_d.pwr = GPC_SLEEP;
      else
         st_d.pwr = GPC_RUN;
      run = (st_d.pwr == GPC_RUN);

      for (int i = 0; i < N_PINS; i++)
      begin
         if (I_ALT_EN[i])
         begin
            drv_dir = I_ALT_OE[i];
            drv_out = I_ALT_OUT[i];
         end
         else
         begin
            drv_dir = st_q.dir[i];
            drv_out = st_q.out[i];
         end
         // bus mode never drives high: a one releases the line
         if (is_bus_pin(i) && st_q.bus_mode)
         begin
            eff_dir[i] = drv_dir & ~drv_out;
            eff_out[i] = 1'b0;
         end
         else
         begin
            eff_dir[i] = drv_dir;
            eff_out[i] = drv_out;
         end
      end

      // snapshot the pin drive on the cycle sleep begins
      if (!run && (st_q.pwr == GPC_RUN))
      begin
         st_d.hold_dir = eff_dir;
         st_d.hold_out = eff_out;
      end

      if (run)
      begin
         st_d.pad_oe_n = ~eff_dir;
         st_d.pad_out  = eff_out;
      end
      else
      begin
         st_d.pad_oe_n = ~st_d.hold_dir;
         st_d.pad_out  = st_d.hold_out;
      end

      st_d.periph_on = 1'b1;
      st_d.adc_pwr   = run & I_ADC_EN;
      // comparator survives plain sleep only to serve as a wake source
      st_d.cmp_pwr   = I_CMP_EN & (run | ((st_d.pwr == GPC_SLEEP)
                                          & st_q.cmp_wake));
      st_d.filt      = {filt_en[`GPC_BUS_PIN_B], filt_en[`GPC_BUS_PIN_A]};

      for (int k = 0; k < `GPC_ADC_NSH; k++)
         st_d.ana_sw[`GPC_ADC_PIN0 + k] = st_d.adc_pwr
            & (I_ADC_CH == (`GPC_ADC_CH0 + 3'(k)));
      for (int i = 0; i < N_PINS; i++)
         if (is_cmp_pin(i))
            st_d.ana_sw[i] = st_d.cmp_pwr;

      st_d.in_prev  = in_lvl;
      st_d.cmp_prev = cmp_lvl[0];
      pin_evt       = (in_lvl ^ st_q.in_prev) & st_q.irq & ~st_q.hold_dir;
      st_d.wake     = 1'b0;
      if (st_q.pwr != GPC_RUN)
         st_d.wake = (|pin_evt);
      if ((st_q.pwr == GPC_SLEEP) && st_q.cmp_wake && st_q.cmp_pwr
          && (cmp_lvl[0] != st_q.cmp_prev))
         st_d.wake = 1'b1;
   end

   always_ff @(posedge I_CORE_CLK)
   begin
      if (!I_RSTN)
      begin
         st_q           <= '0;
         st_q.pwr       <= GPC_RUN;
         st_q.dir       <= {N_PINS{`GPC_DIR_RST}};
         st_q.out       <= {N_PINS{`GPC_OUT_RST}};
         st_q.pull      <= {N_PINS{`GPC_PULL_RST}};
         st_q.pad_oe_n  <= {N_PINS{`GPC_OEN_OFF}};
         st_q.periph_on <= 1'b0;
         st_q.adc_pwr   <= 1'b0;
         st_q.cmp_pwr   <= 1'b0;
      end
      else
         st_q <= st_d;
   end

   assign O_PAD_OUT     = st_q.pad_out;
   assign O_PAD_OE_N    = st_q.pad_oe_n;
   assign O_PULL_EN     = st_q.pull;
   assign O_ANA_SW      = st_q.ana_sw;
   assign O_BUS_FILT_EN = st_q.filt;
   assign O_RD_DIR      = st_q.dir;
   assign O_RD_OUT      = st_q.out;
   assign O_RD_PULL     = st_q.pull;
   assign O_RD_IN       = in_lvl;
   assign O_PERIPH_ON   = st_q.periph_on;
   assign O_ADC_PWR     = st_q.adc_pwr;
   assign O_CMP_PWR     = st_q.cmp_pwr;
   assign O_VREF_EXT    = st_q.vref_ext;
   assign O_WAKE        = st_q.wake;
   assign O_PWR_STATE   = st_q.pwr;

endmodule : gpc_top

// ===== test/gpc_top_props.sv
`timescale 1ns/1ps
module gpc_top_props #(
   parameter int N_PINS = 20
) (
   input wire logic              I_CORE_CLK,
   input wire logic              I_RSTN,
   input wire logic              I_CFG_WE,
   input wire logic [N_PINS-1:0] I_CFG_PULL,
   input wire logic [N_PINS-1:0] I_ALT_EN,
   input wire logic [N_PINS-1:0] I_ALT_OE,
   input wire logic [2:0]        I_ADC_CH,
   input wire logic [N_PINS-1:0] O_PAD_OUT,
   input wire logic [N_PINS-1:0] O_PAD_OE_N,
   input wire logic [N_PINS-1:0] O_PULL_EN,
   input wire logic [N_PINS-1:0] O_ANA_SW,
   input wire logic [1:0]        O_BUS_FILT_EN,
   input wire logic [N_PINS-1:0] O_RD_DIR,
   input wire logic [N_PINS-1:0] O_RD_PULL,
   input wire logic              O_PERIPH_ON,
   input wire logic              O_ADC_PWR,
   input wire logic              O_CMP_PWR,
   input wire logic              O_WAKE,
   input gpc_pkg::gpc_pwr_e      O_PWR_STATE
);
   import gpc_pkg::*;
   // bus pins change meaning with bus mode, so they have their own check
   localparam logic [N_PINS-1:0] MSK = ~(N_PINS'(3) << 4);
   default clocking cb @(posedge I_CORE_CLK); endclocking
   default disable iff (!I_RSTN);
   property p_rst;
      disable iff (1'b0) !I_RSTN |=> &O_PAD_OE_N && &O_PULL_EN
         && &O_RD_PULL && !O_PERIPH_ON && !O_ADC_PWR && !O_CMP_PWR;
   endproperty
   a_rst: assert property (p_rst) else $error("bad reset state");
   property p_pull_cfg;
      I_CFG_WE |=> O_RD_PULL == $past(I_CFG_PULL);
   endproperty
   a_pull_cfg: assert property (p_pull_cfg) else $error("pull");
   property p_pull_pad;
      !$past(I_CFG_WE) |-> $stable(O_PULL_EN) && O_PULL_EN == O_RD_PULL;
   endproperty
   a_pull_pad: assert property (p_pull_pad) else $error("pull pad");
   property p_own_dir;
      O_PWR_STATE == GPC_RUN && $past(O_PWR_STATE) == GPC_RUN |->
         ((O_PAD_OE_N ^ ~$past(O_RD_DIR)) & ~$past(I_ALT_EN) & MSK) == '0;
   endproperty
   a_own_dir: assert property (p_own_dir) else $error("own dir");
   property p_alt_dir;
      O_PWR_STATE == GPC_RUN && $past(O_PWR_STATE) == GPC_RUN |->
         ((O_PAD_OE_N ^ ~$past(I_ALT_OE)) & $past(I_ALT_EN) & MSK) == '0;
   endproperty
   a_alt_dir: assert property (p_alt_dir) else $error("alt dir");
   property p_bus_od;
      |O_BUS_FILT_EN && $stable(O_BUS_FILT_EN) |->
         (O_PAD_OUT[5:4] & O_BUS_FILT_EN) == 2'b00;
   endproperty
   a_bus_od: assert property (p_bus_od) else $error("bus high");
   property p_ana_pwr;
      O_PWR_STATE != GPC_RUN && $stable(O_PWR_STATE) |->
         !O_ADC_PWR && !(O_PWR_STATE == GPC_DEEP && O_CMP_PWR);
   endproperty
   a_ana_pwr: assert property (p_ana_pwr) else $error("analog on");
   property p_hold;
      O_PWR_STATE != GPC_RUN && $past(O_PWR_STATE) != GPC_RUN |->
         $stable(O_PAD_OE_N) && $stable(O_PAD_OUT);
   endproperty
   a_hold: assert property (p_hold) else $error("pads moved");
   property p_ana_sw;
      |O_ANA_SW[3:0] |-> O_ANA_SW[16:4] == '0
         && O_ANA_SW[3:0] == 4'h1 << ($past(I_ADC_CH) - 3'h2);
   endproperty
   a_ana_sw: assert property (p_ana_sw) else $error("ana sw");
   property p_wake;
      O_WAKE |-> $past(O_PWR_STATE) != GPC_RUN;
   endproperty
   a_wake: assert property (p_wake) else $error("wake in run");
endmodule : gpc_top_props
bind gpc_top gpc_top_props #(
   .N_PINS (N_PINS)
) gpc_top_props_inst (
   .I_CORE_CLK    (I_CORE_CLK),
   .I_RSTN        (I_RSTN),
   .I_CFG_WE      (I_CFG_WE),
   .I_CFG_PULL    (I_CFG_PULL),
   .I_ALT_EN      (I_ALT_EN),
   .I_ALT_OE      (I_ALT_OE),
   .I_ADC_CH      (I_ADC_CH),
   .O_PAD_OUT     (O_PAD_OUT),
   .O_PAD_OE_N    (O_PAD_OE_N),
   .O_PULL_EN     (O_PULL_EN),
   .O_ANA_SW      (O_ANA_SW),
   .O_BUS_FILT_EN (O_BUS_FILT_EN),
   .O_RD_DIR      (O_RD_DIR),
   .O_RD_PULL     (O_RD_PULL),
   .O_PERIPH_ON   (O_PERIPH_ON),
   .O_ADC_PWR     (O_ADC_PWR),
   .O_CMP_PWR     (O_CMP_PWR),
   .O_WAKE        (O_WAKE),
   .O_PWR_STATE   (O_PWR_STATE)
);

// ===== test/gpc_board.sv
`timescale 1ns/1ps
module gpc_board #(
   parameter int N = 20
) (
   input  wire logic [N-1:0] i_pad_out,
   input  wire logic [N-1:0] i_oe_n,
   input  wire logic [N-1:0] i_pull_en,
   input  wire logic [N-1:0] i_ext,
   output logic      [N-1:0] o_pad_in
);
   // a released pad with its pull off follows what the board applies
   assign o_pad_in = (~i_oe_n & i_pad_out) | (i_oe_n & i_pull_en)
                   | (i_oe_n & ~i_pull_en & i_ext);
endmodule : gpc_board

// ===== test/tb_gpc_top.sv
`timescale 1ns/1ps
module tb_gpc_top;
   import gpc_pkg::*;
   logic clk = 1'b0, rstn, we, bus, vext, cwake, adc_en, cmp_en, cmp_out;
   logic slp, dslp, periph, adc_pwr, cmp_pwr, vref, wake;
   logic [19:0] dir, out, pull, irq, alt_en, alt_oe, alt_out, ext, pad_in;
   logic [19:0] pad_out, oe_n, pull_en, ana, rd_dir, rd_out, rd_pull, rd_in;
   logic [19:0] e_dir, e_out, e_in;
   logic [1:0]  filt;
   logic [2:0]  adc_ch;
   gpc_pwr_e    pst;
   int failures = 0, comparisons = 0, i, k, seed = 32'h5682e64e;
   always #20 clk = ~clk;
   gpc_top gpc_top_inst (.I_CORE_CLK(clk), .I_RSTN(rstn), .I_CFG_WE(we),
      .I_CFG_DIR(dir), .I_CFG_OUT(out), .I_CFG_PULL(pull), .I_CFG_IRQ(irq),
      .I_CFG_BUS_MODE(bus), .I_CFG_VREF_EXT(vext), .I_CFG_CMP_WAKE(cwake),
      .I_ALT_EN(alt_en), .I_ALT_OE(alt_oe), .I_ALT_OUT(alt_out),
      .I_ADC_EN(adc_en), .I_ADC_CH(adc_ch), .I_CMP_EN(cmp_en),
      .I_CMP_OUT(cmp_out), .I_SLEEP(slp), .I_DEEP_SLEEP(dslp),
      .I_PAD_IN(pad_in), .O_PAD_OUT(pad_out), .O_PAD_OE_N(oe_n),
      .O_PULL_EN(pull_en), .O_ANA_SW(ana), .O_BUS_FILT_EN(filt),
      .O_RD_DIR(rd_dir), .O_RD_OUT(rd_out), .O_RD_PULL(rd_pull),
      .O_RD_IN(rd_in), .O_PERIPH_ON(periph), .O_ADC_PWR(adc_pwr),
      .O_CMP_PWR(cmp_pwr), .O_VREF_EXT(vref), .O_WAKE(wake),
      .O_PWR_STATE(pst));
   gpc_board gpc_board_inst (.i_pad_out(pad_out), .i_oe_n(oe_n),
      .i_pull_en(pull_en), .i_ext(ext), .o_pad_in(pad_in));
   task automatic chk(input logic [19:0] s, input logic [19:0] e);
      comparisons++;
      if (s !== e)
      begin
         failures++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : chk
   task automatic wr;
      we = 1'b1;
      @(negedge clk);
      we = 1'b0;
   endtask : wr
   // a wake pulse lasts one cycle, so poll it every cycle
   task automatic ww;
      for (k = 0; k < 12 && wake !== 1'b1; k++) @(negedge clk);
   endtask : ww
   task automatic stop_test;
      $display("failures=%0d comparisons=%0d", failures, comparisons);
      if (failures == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : stop_test
   initial
   begin
      #40000;
      failures++;
      stop_test();
   end
   initial
   begin
      {we, bus, vext, cwake, adc_en, cmp_en, cmp_out, slp, dslp} = '0;
      {dir, out, pull, irq, alt_en, alt_oe, alt_out, ext} = '0;
      adc_ch = 3'h2;
      rstn = 1'b0;
      repeat (16) @(negedge clk);
      chk(oe_n, '1);
      chk(pull_en, '1);
      chk(periph, 1'b0);
      rstn = 1'b1;
      repeat (2) @(negedge clk);
      chk(periph, 1'b1);
      for (i = 0; i < 8; i++)
      begin
         dir     = 20'($random(seed));
         out     = 20'($random(seed));
         pull    = 20'($random(seed));
         ext     = 20'($random(seed));
         alt_en  = 20'($random(seed));
         alt_oe  = 20'($random(seed));
         alt_out = 20'($random(seed));
         bus = i[0];
         wr();
         repeat (12) @(negedge clk);
         e_dir = (alt_en & alt_oe) | (~alt_en & dir);
         e_out = (alt_en & alt_out) | (~alt_en & out);
         if (bus)
         begin
            e_dir[5:4] = e_dir[5:4] & ~e_out[5:4];
            e_out[5:4] = 2'b00;
         end
         e_in = (e_dir & e_out) | (~e_dir & (pull | ext));
         chk(rd_dir, dir);
         chk(rd_out, out);
         chk(rd_pull, pull);
         chk(vref, vext);
         chk(oe_n, ~e_dir);
         chk(pad_out, e_out);
         chk(pull_en, pull);
         chk(filt, {bus, bus});
         chk(rd_in, e_in);
      end
      {dir, pull, alt_en, bus, vext} = {60'h0, 1'b0, 1'b1};
      wr();
      {adc_en, cmp_en} = 2'b11;
      for (i = 2; i < 6; i++) // channel 1 unused with ext ref
      begin
         adc_ch = i[2:0];
         repeat (3) @(negedge clk);
         chk(ana, 20'h60000 | (20'h1 << (i - 2)));
      end
      chk(vref, 1'b1);
      chk(adc_pwr, 1'b1);
      {dir, out, irq, cwake} = {20'h0ff00, 20'h0aa00, 20'h00040, 1'b1};
      wr();
      repeat (12) @(negedge clk);
      slp = 1'b1;
      repeat (3) @(negedge clk);
      chk(pst, GPC_SLEEP);
      {dir, alt_en, alt_oe} = {20'h0, 20'hfffff, 20'hfffff};
      wr();
      repeat (4) @(negedge clk);
      chk(oe_n, 20'hf00ff);
      chk(pad_out, 20'h0aa00);
      chk(adc_pwr, 1'b0);
      chk(cmp_pwr, 1'b1);
      ext[6] = ~ext[6];
      ww();
      chk(wake, 1'b1);
      repeat (2) @(negedge clk);
      cmp_out = 1'b1;
      ww();
      chk(wake, 1'b1);
      dslp = 1'b1;
      repeat (3) @(negedge clk);
      chk(pst, GPC_DEEP);
      chk(cmp_pwr, 1'b0);
      {slp, dslp} = 2'b00;
      repeat (4) @(negedge clk);
      chk(pst, GPC_RUN);
      stop_test();
   end
endmodule : tb_gpc_top
